// *** rtl/fpes_host.sv ***
// host controller that sequences program and erase commands on a parallel flash
// Functional notes
// - any number of programs may follow one another with the same sequence
// - full error decoding is optional once the ready flag is set
// - after an operation the device returns status until read-array is written
// - further blocks are erased by repeating setup then confirm per block
// - erase begins with the setup code written at any address
// - second erase cycle carries a block address with the confirm code
// - clear-status code resets supply, program and erase error flags
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fpes_host
  import fpes_pkg::*;
#(
  parameter int AW = 18,
  parameter int DW = 16
)(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  input  wire logic [2:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  output logic               irq,
  output logic [AW-1:0]      flash_a,
  input  wire logic [DW-1:0] flash_dq_in,
  output logic [DW-1:0]      flash_dq_out,
  output logic               flash_dq_oe,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n
);
  typedef enum logic [3:0] {
    FPES_IDLE     = 4'b0000,
    FPES_CMD1     = 4'b0001,
    FPES_CMD2     = 4'b0011,
    FPES_POLL     = 4'b0010,
    FPES_CHECK    = 4'b0110,
    FPES_FINISH   = 4'b0111,
    FPES_ARRAY    = 4'b0101,
    FPES_ARRAYRD  = 4'b0100
  } fpes_st_e;

  // events: 0 done, 1 error, 2 paused, 3 refused
  typedef struct packed {
    fpes_st_e      st;
    logic [2:0]    op;
    logic          busy;
    logic          lock;
    logic [7:0]    status;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [DW-1:0] rdbuf;
    logic [3:0]    evt;
    logic [3:0]    mask;
    logic          cyc_start;
    logic          cyc_wr;
    logic [AW-1:0] cyc_a;
    logic [DW-1:0] cyc_d;
    logic          susp_req;
    logic [31:0]   rdata;
    logic          irq;
  } fpes_s;
  fpes_s s_reg;
  fpes_s s_next;

  logic          cyc_done;
  logic [DW-1:0] cyc_rdata;

  fpes_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .start    (s_reg.cyc_start),
    .is_write (s_reg.cyc_wr),
    .addr     (s_reg.cyc_a),
    .wdata    (s_reg.cyc_d),
    .dq_in    (flash_dq_in),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .a_out    (flash_a),
    .dq_out   (flash_dq_out),
    .dq_oe    (flash_dq_oe),
    .ce_n     (flash_ce_n),
    .we_n     (flash_we_n),
    .oe_n     (flash_oe_n)
  );

  always_comb
  begin
    logic [3:0] evt_set;
    logic [7:0] sr;
    evt_set = 4'h0;
    sr = cyc_rdata[7:0];
    s_next = s_reg;
    s_next.cyc_start = 1'b0;
    unique case (s_reg.st)
      FPES_IDLE:
      begin
        if (s_reg.busy)
        begin
          s_next.busy = 1'b0;
          s_next.cyc_start = 1'b1;
          s_next.cyc_wr = 1'b1;
          s_next.cyc_a = s_reg.addr;
          s_next.st = FPES_CMD1;
          unique case (s_reg.op)
            OP_PROGRAM:
              s_next.cyc_d = DW'(CMD_PROG_SETUP);
            OP_ERASE:
              s_next.cyc_d = DW'(CMD_ERASE_SETUP);
            OP_CLEAR:
              s_next.cyc_d = DW'(CMD_CLEAR_STATUS);
            OP_READ_ARRAY:
              s_next.cyc_d = DW'(CMD_READ_ARRAY);
            OP_RESUME:
            begin
              // no setup cycle: a setup code here would start a fresh erase
              s_next.cyc_d = DW'(CMD_CONFIRM);
              s_next.st = FPES_CMD2;
            end
            default:
              s_next.cyc_d = DW'(CMD_READ_ARRAY);
          endcase
        end
      end
      FPES_CMD1:
      begin
        if (cyc_done)
        begin
          unique case (s_reg.op)
            OP_PROGRAM, OP_ERASE:
            begin
              s_next.cyc_start = 1'b1;
              s_next.cyc_a = s_reg.addr;
              s_next.cyc_d = (s_reg.op == OP_PROGRAM) ? s_reg.data : DW'(CMD_CONFIRM);
              s_next.st = FPES_CMD2;
            end
            OP_CLEAR:
            begin
              s_next.status[SR_ERASE_ERR_BIT:SR_SUPPLY_BIT] = 3'h0;
              s_next.lock = 1'b0;
              s_next.st = FPES_FINISH;
            end
            OP_READ_ARRAY:
              s_next.st = FPES_ARRAY;
            default:
              s_next.st = FPES_FINISH;
          endcase
        end
      end
      FPES_CMD2:
      begin
        if (cyc_done)
        begin
          s_next.cyc_start = 1'b1;
          s_next.cyc_wr = 1'b0;
          s_next.st = FPES_POLL;
        end
      end
      FPES_POLL:
      begin
        if (cyc_done)
        begin
          s_next.status = sr;
          if (sr[SR_READY_BIT])
            s_next.st = FPES_CHECK;
          else if (s_reg.susp_req && (s_reg.op == OP_ERASE || s_reg.op == OP_RESUME))
          begin
            s_next.susp_req = 1'b0;
            s_next.cyc_start = 1'b1;
            s_next.cyc_wr = 1'b1;
            s_next.cyc_d = DW'(CMD_SUSPEND);
            s_next.st = FPES_CMD2;
          end
          else
          begin
            s_next.cyc_start = 1'b1;
            s_next.cyc_wr = 1'b0;
          end
        end
      end
      FPES_CHECK:
      begin
        // only the supply flag sets the lock; any of bits 5:3 raises the error event, paused with ready the paused event
        if (s_reg.status[SR_SUPPLY_BIT])
          s_next.lock = 1'b1;
        if (|s_reg.status[SR_ERASE_ERR_BIT:SR_SUPPLY_BIT])
          evt_set[1] = 1'b1;
        if (s_reg.status[SR_PAUSED_BIT] && s_reg.status[SR_READY_BIT])
          evt_set[2] = 1'b1;
        s_next.st = FPES_FINISH;
      end
      FPES_ARRAY:
      begin
        s_next.cyc_start = 1'b1;
        s_next.cyc_wr = 1'b0;
        s_next.st = FPES_ARRAYRD;
      end
      FPES_ARRAYRD:
      begin
        if (cyc_done)
        begin
          s_next.rdbuf = cyc_rdata;
          s_next.st = FPES_FINISH;
        end
      end
      FPES_FINISH:
      begin
        evt_set[0] = 1'b1;
        // a suspend that came too late is dropped here; one written in this cycle or while idle can still pause the next erase
        s_next.susp_req = 1'b0;
        s_next.st = FPES_IDLE;
      end
      default:
        s_next.st = FPES_IDLE;
    endcase

    s_next.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL:   s_next.rdata = {27'h000_0000, s_reg.lock, s_reg.busy || s_reg.st != FPES_IDLE, s_reg.op};
        REG_ADDR:   s_next.rdata = 32'(s_reg.addr);
        REG_DATA:   s_next.rdata = 32'(s_reg.data);
        REG_STATUS: s_next.rdata = {24'h00_0000, s_reg.status};
        REG_EVENT:  s_next.rdata = {28'h000_0000, s_reg.evt};
        REG_MASK:   s_next.rdata = {28'h000_0000, s_reg.mask};
        REG_RDATA:  s_next.rdata = 32'(s_reg.rdbuf);
        default:    s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr)
    begin
      unique case (reg_addr)
        REG_CTRL:
        begin
          if (reg_wdata[2:0] == OP_SUSPEND)
            s_next.susp_req = 1'b1;
          else if (s_reg.st == FPES_IDLE && !s_reg.busy && reg_wdata[2:0] != OP_NONE)
          begin
            if (s_reg.lock && (reg_wdata[2:0] == OP_PROGRAM || reg_wdata[2:0] == OP_ERASE))
              evt_set[3] = 1'b1;
            else
            begin
              // resume writes only the confirm code, then polls like an erase
              s_next.op = reg_wdata[2:0];
              s_next.busy = 1'b1;
            end
          end
        end
        REG_ADDR: s_next.addr = reg_wdata[AW-1:0];
        REG_DATA: s_next.data = reg_wdata[DW-1:0];
        REG_MASK: s_next.mask = reg_wdata[3:0];
        default:  s_next.mask = s_reg.mask;
      endcase
    end
    // read clears, but an event in the same cycle survives
    if (reg_rd && reg_addr == REG_EVENT)
      s_next.evt = evt_set;
    else
      s_next.evt = s_reg.evt | evt_set;
    s_next.irq = |(s_next.evt & s_next.mask);
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.st <= FPES_IDLE;
      s_reg.status <= STAT_RESET;
      s_reg.evt <= EVT_RESET;
    end
    else if (clk_en)
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign irq = s_reg.irq;
endmodule
`default_nettype wire

// *** rtl/fpes_pkg.sv ***
// package of constants for the flash program/erase sequencer host
package fpes_pkg;
  localparam logic [7:0]  CMD_READ_ARRAY   = 8'h00_FF;
  localparam logic [7:0]  CMD_READ_STATUS  = 8'h00_70;
  localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h00_50;
  localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h00_20;
  localparam logic [7:0]  CMD_CONFIRM      = 8'h00_D0;
  localparam logic [7:0]  CMD_SUSPEND      = 8'h00_B0;
  localparam logic [7:0]  CMD_PROG_SETUP   = 8'h00_40;
  localparam int          SR_SUPPLY_BIT    = 3;
  localparam int          SR_PROG_ERR_BIT  = 4;
  localparam int          SR_ERASE_ERR_BIT = 5;
  localparam int          SR_PAUSED_BIT    = 6;
  localparam int          SR_READY_BIT     = 7;
  localparam logic [2:0]  REG_CTRL         = 3'h0;
  localparam logic [2:0]  REG_ADDR         = 3'h1;
  localparam logic [2:0]  REG_DATA         = 3'h2;
  localparam logic [2:0]  REG_STATUS       = 3'h3;
  localparam logic [2:0]  REG_EVENT        = 3'h4;
  localparam logic [2:0]  REG_MASK         = 3'h5;
  localparam logic [2:0]  REG_RDATA        = 3'h6;
  localparam logic [2:0]  OP_NONE          = 3'h0;
  localparam logic [2:0]  OP_PROGRAM       = 3'h1;
  localparam logic [2:0]  OP_ERASE         = 3'h2;
  localparam logic [2:0]  OP_CLEAR         = 3'h3;
  localparam logic [2:0]  OP_READ_ARRAY    = 3'h4;
  localparam logic [2:0]  OP_SUSPEND       = 3'h5;
  localparam logic [2:0]  OP_RESUME        = 3'h6;
  localparam int          WE_LOW_NS        = 100;
  localparam int          CLK_NS           = 100;
  localparam int          WE_LOW_CYC       = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RD_WAIT_NS       = 100;
  localparam int          RD_WAIT_CYC      = (RD_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  EVT_RESET        = 4'h0;
  localparam logic [7:0]  STAT_RESET       = 8'h00_00;
  typedef enum logic [2:0] {
    FPES_CYC_IDLE  = 3'b000,
    FPES_CYC_SETUP = 3'b001,
    FPES_CYC_STROBE= 3'b011,
    FPES_CYC_HOLD  = 3'b010,
    FPES_CYC_DONE  = 3'b110
  } fpes_cyc_e;
endpackage

// *** rtl/fpes_bus_cycle.sv ***
// one write or read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fpes_bus_cycle
  import fpes_pkg::*;
#(
  parameter int AW = 18,
  parameter int DW = 16
)(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  input  wire logic          start,
  input  wire logic          is_write,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [DW-1:0] dq_in,
  output logic               done,
  output logic [DW-1:0]      rdata,
  output logic [AW-1:0]      a_out,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe,
  output logic               ce_n,
  output logic               we_n,
  output logic               oe_n
);
  typedef struct packed {
    fpes_cyc_e     st;
    logic [3:0]    cnt;
    logic          wr;
    logic          done;
    logic [DW-1:0] rdata;
    logic [AW-1:0] a;
    logic [DW-1:0] dq;
    logic          oe;
    logic          ce_n;
    logic          we_n;
    logic          oe_n;
  } fpes_cyc_s;
  fpes_cyc_s s_reg;
  fpes_cyc_s s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      FPES_CYC_IDLE:
      begin
        if (start)
        begin
          s_next.st = FPES_CYC_SETUP;
          s_next.wr = is_write;
          s_next.a = addr;
          s_next.dq = wdata;
          s_next.oe = is_write;
          s_next.ce_n = 1'b0;
        end
      end
      FPES_CYC_SETUP:
      begin
        s_next.st = FPES_CYC_STROBE;
        s_next.cnt = 4'((s_reg.wr ? WE_LOW_CYC : RD_WAIT_CYC) - 1);
        if (s_reg.wr)
          s_next.we_n = 1'b0;
        else
          s_next.oe_n = 1'b0;
      end
      FPES_CYC_STROBE:
      begin
        if (s_reg.cnt != 4'h0)
          s_next.cnt = s_reg.cnt - 4'h1;
        else
        begin
          s_next.st = FPES_CYC_HOLD;
          if (!s_reg.wr)
            s_next.rdata = dq_in;
          s_next.we_n = 1'b1;
          s_next.oe_n = 1'b1;
        end
      end
      FPES_CYC_HOLD:
      begin
        // data held past the rising strobe before release
        s_next.st = FPES_CYC_DONE;
        s_next.oe = 1'b0;
        s_next.ce_n = 1'b1;
      end
      FPES_CYC_DONE:
      begin
        s_next.st = FPES_CYC_IDLE;
        s_next.done = 1'b1;
      end
      default:
        s_next.st = FPES_CYC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.st <= FPES_CYC_IDLE;
      s_reg.ce_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
    end
    else if (clk_en)
      s_reg <= s_next;
  end

  assign done = s_reg.done;
  assign rdata = s_reg.rdata;
  assign a_out = s_reg.a;
  assign dq_out = s_reg.dq;
  assign dq_oe = s_reg.oe;
  assign ce_n = s_reg.ce_n;
  assign we_n = s_reg.we_n;
  assign oe_n = s_reg.oe_n;
endmodule
`default_nettype wire

// *** sim/fpes_host_properties.sv ***
// port assertions for the flash sequencer host
`timescale 1ns/1ps
`default_nettype none
module fpes_host_properties
  import fpes_pkg::*;
#(
  parameter int AW = 18,
  parameter int DW = 16
)(
  input wire logic          core_clk,
  input wire logic          nrst,
  input wire logic          clk_en,
  input wire logic [2:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  input wire logic          irq,
  input wire logic [AW-1:0] flash_a,
  input wire logic [DW-1:0] flash_dq_in,
  input wire logic [DW-1:0] flash_dq_out,
  input wire logic          flash_dq_oe,
  input wire logic          flash_ce_n,
  input wire logic          flash_we_n,
  input wire logic          flash_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence we_pulse;
    !flash_we_n ##1 flash_we_n;
  endsequence
  sequence ce_held;
    !flash_ce_n [*2];
  endsequence
  sequence oe_pulse;
    !flash_oe_n ##1 flash_oe_n;
  endsequence
  chk_rd_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  chk_we_pulse: assert property ($fell(flash_we_n) |-> we_pulse)
    else $error("write strobe not one cycle");
  chk_ce_frame: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n) ##0 ce_held)
    else $error("chip select does not frame write strobe");
  chk_we_data: assert property (!flash_we_n |-> flash_dq_oe && $stable(flash_dq_out) && $stable(flash_a))
    else $error("address or data moved under write strobe");
  chk_oe_we_excl: assert property (flash_we_n || flash_oe_n)
    else $error("read and write strobes together");
  chk_no_clash: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data while flash outputs");
  chk_oe_ce: assert property (!flash_oe_n |-> !flash_ce_n)
    else $error("output enable without chip select");
  chk_irq_drop: assert property ($fell(irq) |-> $past(reg_rd) || $past(reg_wr) || $past(reg_rd, 2) || $past(reg_wr, 2))
    else $error("interrupt dropped without register access");
  chk_oe_pulse: assert property ($fell(flash_oe_n) |-> oe_pulse)
    else $error("read strobe not one cycle");
  chk_freeze_hold: assert property (!clk_en |=> $stable(reg_rdata) && $stable(irq) && $stable(flash_ce_n))
    else $error("outputs moved while clock enable low");
endmodule
bind fpes_host fpes_host_properties #(.AW(AW), .DW(DW)) fpes_host_properties_i (
  .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .flash_a(flash_a),
  .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
`default_nettype wire

// *** sim/fpes_flash_model.sv ***
// behavioural parallel flash with command logic and status register
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model
  import fpes_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [17:0] a,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        vpp_bad,
  input  wire logic [7:0]  op_len,
  output logic      [15:0] dq_in
);
  logic [15:0] mem [logic [17:0]];
  logic [5:3]  err = 3'b000;
  logic        pz = 0, sus = 0, arm_pg = 0, arm_er = 0, stat = 0, we_d = 1;
  logic [15:0] hold = 16'h0000;
  logic [5:0]  er_blk = 6'h00;
  int          busy = 0, pg_cnt = 0, er_cnt = 0;
  wire  logic [7:0] st = {busy == 0 || pz, pz, err, 3'b000};
  // state moves on the falling edge so the host never samples it mid-update
  always @(negedge core_clk)
  begin
    if (sus) pz = 1;
    sus = 0;
    if (busy > 0 && !pz) busy--;
    if (we_n && !we_d && !ce_n && dq_oe)
    begin
      stat = 1;
      if (arm_pg || arm_er)
      begin
        if (arm_er && dq_out[7:0] != CMD_CONFIRM) err[5:4] = 2'b11;
        else if (vpp_bad) err = {arm_er, arm_pg, 1'b1};
        else if (!err[3])
        begin
          busy = op_len;
          if (arm_pg) begin mem[a] = dq_out; pg_cnt++; end
          else begin er_blk = a[17:12]; er_cnt++; end
        end
        arm_pg = 0;
        arm_er = 0;
      end
      else case (dq_out[7:0])
        CMD_PROG_SETUP:   arm_pg = 1;
        CMD_ERASE_SETUP:  arm_er = 1;
        CMD_CLEAR_STATUS: err = 3'b000;
        CMD_READ_ARRAY:   stat = 0;
        CMD_SUSPEND:      sus = busy > 0;
        CMD_CONFIRM:      pz = 0;
        default:          ;
      endcase
    end
    we_d = we_n;
    if (!oe_n && !ce_n) hold = dq_in;
  end
  // released bus shows the inverse of its last level so stale data never passes
  always @*
  begin
    dq_in = ~hold;
    if (!oe_n && !ce_n) dq_in = stat ? {8'h00, st} : (mem.exists(a) ? mem[a] : 16'hFFFF);
  end
endmodule
`default_nettype wire

// *** sim/fpes_host_tb.sv ***
// self-checking bench for the flash sequencer host
`timescale 1ns/1ps
`default_nettype none
module fpes_host_tb;
  import fpes_pkg::*;
  logic        core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, vpp_bad = 0, rd_seen = 0, clk_en = 1;
  logic        irq, oe, ce_n, we_n, oe_n;
  logic [2:0]  reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, ev, mv;
  logic [31:0] eq[$], mq[$];
  logic [17:0] fa, ad;
  logic [15:0] dqo, dqi, wd;
  logic [7:0]  op_len = 8'h08;
  int          errors = 0, cmp_count = 0, seed = 44, n, pc = 0;
  fpes_host #(.AW(18), .DW(16)) fpes_host_i (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .flash_a(fa), .flash_dq_in(dqi), .flash_dq_out(dqo), .flash_dq_oe(oe),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n));
  fpes_flash_model fpes_flash_model_i (.core_clk(core_clk), .a(fa), .dq_out(dqo), .dq_oe(oe),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .vpp_bad(vpp_bad), .op_len(op_len), .dq_in(dqi));
  initial forever #50 core_clk = ~core_clk;
  task automatic final_report;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  // the expectation is queued before the strobe so the watcher always finds it
  task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
  endtask
  always @(negedge core_clk)
  begin
    if (rd_seen)
    begin
      ev = eq.pop_front();
      mv = mq.pop_front();
      chk(reg_rdata & mv, ev);
    end
    rd_seen = reg_rd;
  end
  task automatic wait_irq;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge core_clk);
    chk(32'(irq), 32'h0000_0001);
  endtask
  task automatic op(input logic [2:0] code);
    wr(REG_ADDR, 32'(ad));
    wr(REG_DATA, 32'(wd));
    wr(REG_CTRL, 32'(code));
    wait_irq();
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    nrst <= 1;
    rd(REG_CTRL, 32'h0000_0000, '1);
    rd(REG_EVENT, 32'h0000_0000, '1);
    rd(REG_STATUS, 32'h0000_0000, '1);
    rd(3'h7, 32'h0000_0000, '1);
    wr(REG_MASK, 32'h0000_000F);
    rd(REG_MASK, 32'h0000_000F, '1);
    // a write under a low clock enable must be lost
    @(posedge core_clk);
    clk_en <= 0;
    wr(REG_MASK, 32'h0000_0000);
    clk_en <= 1;
    rd(REG_MASK, 32'h0000_000F, '1);
    for (int k = 0; k < 2; k++)
    begin
      ad = 18'($random(seed));
      wd = 16'($random(seed));
      op(OP_PROGRAM);
      pc++;
      rd(REG_EVENT, 32'h0000_0001, 32'h0000_000B);
      chk(32'(fpes_flash_model_i.mem[ad]), 32'(wd));
    end
    rd(REG_STATUS, 32'h0000_0080, 32'h0000_00B8);
    op(OP_READ_ARRAY);
    rd(REG_EVENT, 32'h0000_0001, 32'h0000_0001);
    rd(REG_RDATA, 32'(wd), 32'h0000_FFFF);
    for (int k = 0; k < 2; k++)
    begin
      ad = 18'($random(seed));
      op(OP_ERASE);
      rd(REG_EVENT, 32'h0000_0001, 32'h0000_000B);
      chk(32'(fpes_flash_model_i.er_blk), 32'(ad[17:12]));
      chk(fpes_flash_model_i.er_cnt, k + 1);
    end
    op_len <= 8'hC8;
    wr(REG_ADDR, 32'(ad));
    wr(REG_CTRL, 32'(OP_ERASE));
    repeat (40) @(posedge core_clk);
    wr(REG_CTRL, 32'(OP_SUSPEND));
    wait_irq();
    rd(REG_EVENT, 32'h0000_0004, 32'h0000_0004);
    rd(REG_STATUS, 32'h0000_00C0, 32'h0000_00C0);
    op_len <= 8'h08;
    op(OP_RESUME);
    rd(REG_EVENT, 32'h0000_0001, 32'h0000_0005);
    chk(fpes_flash_model_i.er_cnt, 3);
    vpp_bad <= 1;
    op(OP_PROGRAM);
    rd(REG_EVENT, 32'h0000_0002, 32'h0000_0002);
    vpp_bad <= 0;
    op(OP_PROGRAM);
    rd(REG_EVENT, 32'h0000_0008, 32'h0000_0009);
    chk(fpes_flash_model_i.pg_cnt, pc);
    rd(REG_STATUS, 32'h0000_0018, 32'h0000_0038);
    rd(REG_CTRL, 32'h0000_0010, 32'h0000_0018);
    op(OP_CLEAR);
    rd(REG_EVENT, 32'h0000_0001, 32'h0000_0001);
    op(OP_PROGRAM);
    pc++;
    rd(REG_EVENT, 32'h0000_0001, 32'h0000_000B);
    rd(REG_STATUS, 32'h0000_0080, 32'h0000_00B8);
    chk(fpes_flash_model_i.pg_cnt, pc);
    repeat (4) @(posedge core_clk);
    final_report();
  end
  initial
  begin
    #6_000_000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
